/* File: src/eff_addr_pkg.sv */
package eff_addr_pkg;

    localparam int WORD_W = 24;
    localparam int ADDR_W = 15;
    localparam int CHAR_W = 17;
    localparam int IDX_W = 2;
    localparam int NUM_IDX = 3;
    // instruction word layout: op[23:18] a[17] b[16:15] m[14:0]
    localparam int MODE_POS = 17;
    localparam int IDXD_POS = 15;
    localparam logic [1:0] MIXED_ONES = 2'h3;
    localparam logic [23:0] WORD_RST = 24'h000000;

    typedef enum logic [1:0] {
        KIND_NOADDR,
        KIND_WORD,
        KIND_CHAR,
        KIND_SHIFT
    } kind_t;

    typedef enum logic [1:0] {
        FLAG_NONE,
        FLAG_DESIG,
        FLAG_FIELD,
        FLAG_MIXED
    } flag_mode_t;

    typedef struct packed {
        logic [WORD_W-1:0] word;
        kind_t kind;
        flag_mode_t flag_mode;
        logic [IDX_W-1:0] field_flag;
        logic needs_option;
        logic option_present;
    } instr_req_t;

    typedef struct packed {
        logic [CHAR_W-1:0] addr;
        logic [WORD_W-1:0] word;
        logic trap;
    } ea_result_t;

endpackage

/* File: src/effective_address_generator.sv */
// Functional notes
// - two-bit designator selects one index register
// - modify word, character or shift fields
// - business_data_processor flag: 1,3 first, 2 second
// - mixed indexing adds low fifteen word bits
// - no-address mode takes operand directly
// - mode zero means direct, optionally indexed
// - mode one means indirect, word addresses only
// - indirect chain repeats until mode zero
// - indexing and indirection are independent
// - indirect word replaces address, mode, designator
// - character addresses seventeen bits, never indirect
// - trap instruction when option module missing
// - signal read_next_instruction after each instruction
`timescale 1ns/100ps
module effective_address_generator
    import eff_addr_pkg::*;
(
    input wire logic i_clk, // processor clock
    input wire logic i_rst_n, // async reset, active low
    input wire logic i_start, // take a new instruction
    input wire eff_addr_pkg::instr_req_t i_req, // instruction and decode
    input wire logic [eff_addr_pkg::CHAR_W-1:0] i_index1, // index register 1
    input wire logic [eff_addr_pkg::CHAR_W-1:0] i_index2, // index register 2
    input wire logic [eff_addr_pkg::CHAR_W-1:0] i_index3, // index register 3
    input wire logic i_mem_ack, // storage returns word
    input wire logic [eff_addr_pkg::WORD_W-1:0] i_mem_data, // indirect word
    output logic o_busy, // forming address
    output logic o_mem_req, // storage read request
    output logic [eff_addr_pkg::ADDR_W-1:0] o_mem_addr, // storage read address
    output logic o_done, // result valid pulse
    output eff_addr_pkg::ea_result_t o_result, // effective address
    output logic [7:0] o_levels, // indirect levels taken
    output logic o_read_next // read_next_instruction pulse
);
    import eff_addr_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FORM,
        ST_FETCH,
        ST_NEXT
    } state_t;

    ////////////////////////////////////////////////////////////////////////
    // one's-complement add, end-around carry, width CHAR_W
    function automatic logic [CHAR_W-1:0] oc_add(input logic [CHAR_W-1:0] x,
                                                   input logic [CHAR_W-1:0] y);
        logic [CHAR_W:0] s;
        s = {1'b0, x} + {1'b0, y};
        return s[CHAR_W-1:0] + {{(CHAR_W-1){1'b0}}, s[CHAR_W]};
    endfunction

    // index register selected by number, zero means no indexing
    function automatic logic [CHAR_W-1:0] pick(input logic [1:0] n,
                                                 input logic [CHAR_W-1:0] r1,
                                                 input logic [CHAR_W-1:0] r2,
                                                 input logic [CHAR_W-1:0] r3);
        case (n)
            2'h1: pick = r1;
            2'h2: pick = r2;
            2'h3: pick = r3;
            default: pick = '0;
        endcase
    endfunction

    state_t state_q, state_d;
    instr_req_t req_q;
    logic [WORD_W-1:0] word_q;
    logic [7:0] lev_q;

    ////////////////////////////////////////////////////////////////////////
    // decode of the current (possibly substituted) word
    wire logic mode_bit = word_q[MODE_POS];
    wire logic [1:0] desig = word_q[IDXD_POS+1:IDXD_POS];
    wire logic [1:0] bflag = req_q.field_flag;
    wire logic [1:0] field_sel = (bflag == 2'h3) ? 2'h1 : bflag;
    wire logic [1:0] idx_num = (req_q.flag_mode == FLAG_DESIG) ? desig :
                               (req_q.flag_mode == FLAG_NONE) ? 2'h0 : field_sel;
    wire logic [CHAR_W-1:0] idx_val = pick(idx_num, i_index1, i_index2, i_index3);
    wire logic [CHAR_W-1:0] char_raw = word_q[CHAR_W-1:0];
    // mixed form uses only low fifteen bits
    wire logic [CHAR_W-1:0] word_raw = {2'h0, word_q[ADDR_W-1:0]};
    wire logic [CHAR_W-1:0] base = (req_q.kind == KIND_CHAR) ? char_raw : word_raw;
    wire logic [CHAR_W-1:0] sum17 = oc_add(base, idx_val);
    wire logic [CHAR_W-1:0] modified = (req_q.kind == KIND_CHAR) ? sum17 :
                                       {2'h0, sum17[ADDR_W-1:0]};
    // indirection only for word execution addresses
    wire logic want_ind = (req_q.kind == KIND_WORD) && mode_bit
                          && (req_q.flag_mode == FLAG_DESIG);
    wire logic trap_now = req_q.needs_option && !req_q.option_present;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (i_start) begin
                    state_d = ST_FORM;
                end
            end
            ST_FORM: begin
                if (!trap_now && req_q.kind != KIND_NOADDR && want_ind) begin
                    state_d = ST_FETCH;
                end else begin
                    state_d = ST_NEXT;
                end
            end
            ST_FETCH: begin
                if (i_mem_ack) begin
                    state_d = ST_FORM;
                end
            end
            ST_NEXT: state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= ST_IDLE;
            req_q <= '0;
            word_q <= WORD_RST;
            lev_q <= 8'h00;
            o_busy <= 1'b0;
            o_mem_req <= 1'b0;
            o_mem_addr <= '0;
            o_done <= 1'b0;
            o_result <= '0;
            o_levels <= 8'h00;
            o_read_next <= 1'b0;
        end else begin
            state_q <= state_d;
            o_done <= 1'b0;
            o_read_next <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (i_start) begin
                        req_q <= i_req;
                        word_q <= i_req.word;
                        lev_q <= 8'h00;
                        o_busy <= 1'b1;
                    end
                end
                ST_FORM: begin
                    if (!trap_now && req_q.kind != KIND_NOADDR && want_ind) begin
                        o_mem_req <= 1'b1;
                        o_mem_addr <= modified[ADDR_W-1:0];
                    end else begin
                        o_done <= 1'b1;
                        o_result.trap <= trap_now;
                        o_result.word <= word_q;
                        o_levels <= lev_q;
                        // no-address takes low field as is
                        if (req_q.kind == KIND_NOADDR) begin
                            o_result.addr <= {2'h0, word_q[ADDR_W-1:0]};
                        end else begin
                            o_result.addr <= modified;
                        end
                    end
                end
                ST_FETCH: begin
                    if (i_mem_ack) begin
                        o_mem_req <= 1'b0;
                        word_q <= {word_q[WORD_W-1:MODE_POS+1],
                                   i_mem_data[MODE_POS:0]};
                        lev_q <= lev_q + 8'h01;
                    end
                end
                ST_NEXT: begin
                    o_read_next <= 1'b1;
                    o_busy <= 1'b0;
                end
                default: o_busy <= 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // designator three picks third
    a_idx_select: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state_q == ST_FORM && req_q.flag_mode == FLAG_DESIG && desig == 2'h3)
        |-> idx_val == i_index3) else $error("designator select wrong");

    a_no_flag_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state_q == ST_FORM && req_q.flag_mode == FLAG_NONE)
        |-> idx_val == '0) else $error("index added without flag");

    a_field_flag_map: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state_q == ST_FORM && req_q.flag_mode == FLAG_FIELD && bflag == 2'h3)
        |-> idx_val == i_index1) else $error("flag three must use first");

    a_field_flag_one: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state_q == ST_FORM && req_q.flag_mode == FLAG_FIELD && bflag == 2'h1)
        |-> idx_val == i_index1) else $error("flag one must use first");

    a_field_flag_two: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state_q == ST_FORM && req_q.flag_mode == FLAG_FIELD && bflag == 2'h2)
        |-> idx_val == i_index2) else $error("flag two must use second");

    a_field_flag_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state_q == ST_FORM && req_q.flag_mode == FLAG_FIELD && bflag == 2'h0)
        |-> idx_val == '0) else $error("flag zero must not index");

    a_mixed_low15: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state_q == ST_FORM && req_q.kind != KIND_CHAR && !want_ind && !trap_now)
        |=> o_result.addr[CHAR_W-1:ADDR_W] == 2'h0) else $error("upper word bits used");

    a_noaddr_direct: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state_q == ST_FORM && req_q.kind == KIND_NOADDR)
        |=> o_done && o_result.addr == {2'h0, $past(word_q[ADDR_W-1:0])})
        else $error("no-address operand altered");

    a_noaddr_no_fetch: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state_q == ST_FORM && req_q.kind == KIND_NOADDR)
        |=> !o_mem_req) else $error("no-address form fetched");

    a_direct_no_fetch: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state_q == ST_FORM && !mode_bit)
        |=> !o_mem_req) else $error("direct mode fetched");

    a_char_no_ind: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state_q == ST_FORM && req_q.kind == KIND_CHAR)
        |=> !o_mem_req) else $error("character form went indirect");

    a_char_plain: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state_q == ST_FORM && req_q.kind == KIND_CHAR && req_q.flag_mode == FLAG_NONE)
        |=> o_result.addr == $past(char_raw)) else $error("character address altered");

    a_ind_fetch: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state_q == ST_FORM && want_ind && !trap_now)
        |=> o_mem_req && o_mem_addr == $past(modified[ADDR_W-1:0]))
        else $error("indirect fetch missing");

    a_req_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (o_mem_req && !i_mem_ack)
        |=> o_mem_req && $stable(o_mem_addr)) else $error("request dropped early");

    a_req_drop: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state_q == ST_FETCH && i_mem_ack)
        |=> !o_mem_req) else $error("request not released");

    a_chain_level: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state_q == ST_FETCH && i_mem_ack)
        |=> state_q == ST_FORM && lev_q == $past(lev_q) + 8'h01)
        else $error("level not counted");

    a_levels_match: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_done
        |-> o_levels == lev_q) else $error("level count wrong");

    a_substitute: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state_q == ST_FETCH && i_mem_ack)
        |=> word_q == {$past(word_q[WORD_W-1:MODE_POS+1]), $past(i_mem_data[MODE_POS:0])})
        else $error("indirect word not substituted");

    a_opcode_kept: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_done |-> o_result.word[WORD_W-1:MODE_POS+1] == req_q.word[WORD_W-1:MODE_POS+1])
        else $error("operation code changed");

    a_trap_flag: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state_q == ST_FORM && trap_now)
        |=> o_done && o_result.trap) else $error("trap not flagged");

    a_trap_no_fetch: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state_q == ST_FORM && trap_now)
        |=> !o_mem_req) else $error("trapped instruction fetched");

    a_done_pulse: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_done
        |=> !o_done) else $error("done longer than a cycle");

    a_next_follows: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_done
        |=> o_read_next && !o_busy) else $error("no read next pulse");

    // next step strobe lasts one cycle
    a_next_pulse: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_read_next
        |=> !o_read_next) else $error("read next longer than a cycle");

    a_oc_add: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state_q == ST_FORM && idx_val == '1 && base != '0)
        |-> sum17 == base) else $error("minus zero add changed value");

endmodule

/* File: verif/core_store_model.sv */
`timescale 1ns/100ps
module core_store_model (
    input wire logic i_clk, // processor clock
    input wire logic i_req, // storage read request
    input wire logic [14:0] i_addr, // storage read address
    output logic o_ack, // word returned
    output logic [23:0] o_data // returned word
);
    logic [23:0] words[$];
    logic [14:0] seen[$];
    initial begin
        o_ack = 1'b0;
        o_data = 24'h000000;
        forever begin
            @(posedge i_clk);
            #1;
            if (i_req === 1'b1) begin
                // answer delay varies with the address
                repeat (i_addr[1:0]) @(posedge i_clk);
                #1;
                seen.push_back(i_addr);
                o_data = (words.size() > 0) ? words.pop_front() : 24'h000000;
                o_ack = 1'b1;
                @(posedge i_clk);
                #1;
                o_ack = 1'b0;
                // released data must not look valid
                o_data = ~o_data;
            end
        end
    end
endmodule

/* File: verif/tb_effective_address_generator.sv */
`timescale 1ns/100ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fail_count++; \
    $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module tb_effective_address_generator;
    import eff_addr_pkg::*;
    logic i_clk, i_rst_n, i_start, i_mem_ack, o_busy, o_mem_req, o_done, o_read_next;
    instr_req_t i_req;
    logic [CHAR_W-1:0] i_index1, i_index2, i_index3;
    logic [WORD_W-1:0] i_mem_data;
    logic [ADDR_W-1:0] o_mem_addr;
    ea_result_t o_result;
    logic [7:0] o_levels;
    int fail_count, check_count, seed, n, cyc, lv, depth;
    ////////////////////////////////////////////////////////////////
    effective_address_generator u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_start(i_start),
        .i_req(i_req), .i_index1(i_index1), .i_index2(i_index2), .i_index3(i_index3),
        .i_mem_ack(i_mem_ack), .i_mem_data(i_mem_data), .o_busy(o_busy),
        .o_mem_req(o_mem_req), .o_mem_addr(o_mem_addr), .o_done(o_done),
        .o_result(o_result), .o_levels(o_levels), .o_read_next(o_read_next));
    core_store_model u_mem (.i_clk(i_clk), .i_req(o_mem_req), .i_addr(o_mem_addr),
        .o_ack(i_mem_ack), .o_data(i_mem_data));
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    ////////////////////////////////////////////////////////////////
    function automatic logic [16:0] add1c(logic [16:0] a, logic [16:0] b);
        logic [17:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[16:0] + {16'h0000, s[17]};
    endfunction
    function automatic logic [16:0] ix(logic [1:0] s, logic fld);
        if (s == 2'h2) return i_index2;
        if (s == 2'h1 || (s == 2'h3 && fld)) return i_index1;
        if (s == 2'h3) return i_index3;
        return 17'h00000;
    endfunction
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic run_one();
        logic [23:0] w, cw;
        logic [16:0] f, a;
        logic [14:0] fetch[$];
        logic ind, trap;
        logic [14:0] got_a, exp_a;
        i_req.word = 24'($random(seed));
        i_req.kind = kind_t'(2'($random(seed)));
        i_req.flag_mode = flag_mode_t'(2'($random(seed)));
        if (i_req.kind == KIND_CHAR && i_req.flag_mode != FLAG_NONE) begin
            i_req.flag_mode = FLAG_FIELD;
        end
        i_req.field_flag = 2'($random(seed));
        i_req.needs_option = 2'($random(seed)) == 2'h0;
        i_req.option_present = 1'($random(seed));
        i_index1 = 17'($random(seed));
        i_index2 = 17'($random(seed));
        i_index3 = 17'($random(seed));
        if (3'($random(seed)) == 3'h0) i_index2 = 17'h1ffff;
        if (i_req.flag_mode == FLAG_MIXED) begin
            i_index1[1:0] = MIXED_ONES;
            i_index2[1:0] = MIXED_ONES;
        end
        depth = 1 + int'(2'($random(seed)) % 3);
        trap = i_req.needs_option && !i_req.option_present;
        w = i_req.word;
        lv = 0;
        ind = !trap;
        a = 17'h00000;
        while (ind) begin
            f = (i_req.kind == KIND_CHAR) ? w[16:0] : {2'b00, w[14:0]};
            a = f;
            if (i_req.flag_mode == FLAG_DESIG) a = add1c(f, ix(w[16:15], 1'b0));
            if (i_req.flag_mode inside {FLAG_FIELD, FLAG_MIXED}) begin
                a = add1c(f, ix(i_req.field_flag, 1'b1));
            end
            if (i_req.kind != KIND_CHAR) a[16:15] = 2'b00;
            if (i_req.kind == KIND_NOADDR) a = {2'b00, w[14:0]};
            ind = i_req.kind == KIND_WORD && i_req.flag_mode == FLAG_DESIG && w[MODE_POS];
            if (ind) begin
                fetch.push_back(a[14:0]);
                cw = 24'($random(seed));
                cw[MODE_POS] = lv < depth - 1;
                u_mem.words.push_back(cw);
                w[17:0] = cw[17:0];
                lv++;
            end
        end
        i_start = 1'b1;
        @(posedge i_clk);
        #1;
        i_req.word = ~i_req.word;
        cyc = 0;
        do begin
            @(posedge i_clk);
            #1;
            i_start = 1'b0;
            cyc++;
        end while (o_done !== 1'b1 && cyc < 200);
        `CHK(o_done, 1'b1)
        `CHK(o_result.trap, trap)
        `CHK(o_result.word, w)
        if (!trap) `CHK(o_result.addr, a)
        if (!trap) `CHK(o_levels, 8'(lv))
        if (lv == 0) `CHK(cyc, 1)
        while (fetch.size() > 0) begin
            got_a = u_mem.seen.pop_front();
            exp_a = fetch.pop_front();
            `CHK(got_a, exp_a)
        end
        `CHK(u_mem.seen.size(), 0)
        @(posedge i_clk);
        #1;
        `CHK(o_read_next, 1'b1)
        @(posedge i_clk);
        #1;
        `CHK(o_busy, 1'b0)
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        seed = 2408;
        fail_count = 0;
        check_count = 0;
        i_rst_n = 1'b0;
        i_start = 1'b0;
        i_req = '0;
        i_index1 = 17'h00000;
        i_index2 = 17'h00000;
        i_index3 = 17'h00000;
        repeat (16) @(posedge i_clk);
        #1;
        i_rst_n = 1'b1;
        `CHK(o_done, 1'b0)
        `CHK(o_busy, 1'b0)
        $display("test reset done");
        for (n = 0; n < 300; n++) run_one();
        $display("test random_instructions done");
        end_of_test();
    end
    initial begin
        #(400000);
        fail_count++;
        end_of_test();
    end
endmodule
